// *** logic/tbcr_regs.v ***
// Overview of operation
// - nine-bit read-only sector counter, low byte readable
// - sector counter counts ata pio only, unwritable
// - seed sector counter from byte-count bits 17:9
// - decrement sector counter per 512 bytes
// - nonzero sector count at end means abnormal in ata pio mode only
// - two 32-bit counters share four addresses
// - mcu write loads both counter sets
// - select bit picks which set reads back
// - each set counts its own interface traffic
// - byte counters should reach zero at end
// - four byte registers, ascending, read/write, reset zero
// - sector count msb readable as bit 0
`include "tbcr_defines.vh"
`default_nettype none

module tbcr_regs #(
	parameter BEAT_W = `TBCR_BEAT_W,
	parameter SECTOR_BYTES = `TBCR_SECTOR_BYTES
) (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// mcu data bus
	input wire [15:0] mcu_addr,
	input wire mcu_wr,
	input wire mcu_rd,
	input wire [7:0] mcu_wdata,
	output reg [7:0] mcu_rdata_q,
	output reg mcu_rdata_valid_q,
	output reg mcu_rdata_hit_q,
	// configuration from disk_if_config0
	input wire count_set_read_select,
	input wire ata_pio_mode,
	// usb side traffic
	input wire usb_beat_valid,
	input wire [BEAT_W-1:0] usb_beat_bytes,
	// ata/atapi side traffic
	input wire ata_beat_valid,
	input wire [BEAT_W-1:0] ata_beat_bytes,
	// command end and status
	input wire cmd_end,
	output wire usb_count_zero,
	output wire ata_count_zero,
	output wire sector_count_zero,
	output wire [`TBCR_SECT_W-1:0] sector_counter,
	output reg abnormal_end_q
);

	localparam NB = `TBCR_XFER_BYTES;
	localparam W = 8 * NB;

	// decoded register indices
	localparam [2:0] REG_NONE = 3'h0;
	localparam [2:0] REG_SECT_LOW = 3'h1;
	localparam [2:0] REG_XFER0 = 3'h2;
	localparam [2:0] REG_XFER1 = 3'h3;
	localparam [2:0] REG_XFER2 = 3'h4;
	localparam [2:0] REG_XFER3 = 3'h5;
	localparam [2:0] REG_SECT_MSB = 3'h6;

	function [2:0] tbcr_decode;
		input [15:0] a;
		begin
			if (a == `TBCR_ADDR_SECT_LOW) begin
				tbcr_decode = REG_SECT_LOW;
			end else if (a == `TBCR_ADDR_XFER_B0) begin
				tbcr_decode = REG_XFER0;
			end else if (a == `TBCR_ADDR_XFER_B1) begin
				tbcr_decode = REG_XFER1;
			end else if (a == `TBCR_ADDR_XFER_B2) begin
				tbcr_decode = REG_XFER2;
			end else if (a == `TBCR_ADDR_XFER_B3) begin
				tbcr_decode = REG_XFER3;
			end else if (a == `TBCR_ADDR_SECT_MSB) begin
				tbcr_decode = REG_SECT_MSB;
			end else begin
				tbcr_decode = REG_NONE;
			end
		end
	endfunction

	// picks byte lane n of a 32-bit count
	function [7:0] tbcr_lane;
		input [W-1:0] v;
		input [1:0] n;
		begin
			tbcr_lane = v[8*n +: 8];
		end
	endfunction

	wire [2:0] wr_reg;
	wire [2:0] rd_reg;
	wire [W-1:0] usb_count;
	wire [W-1:0] ata_count;
	wire [W-1:0] sel_count;
	wire [1:0] wr_lane;
	wire [1:0] rd_lane;
	reg [NB-1:0] load_byte_en;
	reg [W-1:0] merged;
	reg seed_en;
	reg [7:0] rdata_d;
	reg hit_d;

	assign wr_reg = tbcr_decode(mcu_addr);
	assign rd_reg = wr_reg;
	assign wr_lane = mcu_addr[1:0] - 2'h2;
	assign rd_lane = wr_lane;

	// byte-lane enables shared by both sets: a write never goes to one set alone
	always @* begin
		load_byte_en = {NB{1'b0}};
		if (mcu_wr) begin
			if (wr_reg == REG_XFER0) begin
				load_byte_en = 4'h1;
			end else if (wr_reg == REG_XFER1) begin
				load_byte_en = 4'h2;
			end else if (wr_reg == REG_XFER2) begin
				load_byte_en = 4'h4;
			end else if (wr_reg == REG_XFER3) begin
				load_byte_en = 4'h8;
			end
		end
	end

	// seed with the count as it stands after this write lands
	always @* begin
		merged = ata_count;
		seed_en = |load_byte_en;
		if (seed_en) begin
			merged[8*wr_lane +: 8] = mcu_wdata;
		end
	end

	// usb set
	tbcr_byte_counter #(
		.NBYTES(NB),
		.BEAT_W(BEAT_W)
	) u_usb_count (
		.clk(clk),
		.rst_b(rst_b),
		.load_byte_en(load_byte_en),
		.load_data(mcu_wdata),
		.beat_valid(usb_beat_valid),
		.beat_bytes(usb_beat_bytes),
		.count_q(usb_count),
		.count_zero(usb_count_zero)
	);

	// ata/atapi set
	tbcr_byte_counter #(
		.NBYTES(NB),
		.BEAT_W(BEAT_W)
	) u_ata_count (
		.clk(clk),
		.rst_b(rst_b),
		.load_byte_en(load_byte_en),
		.load_data(mcu_wdata),
		.beat_valid(ata_beat_valid),
		.beat_bytes(ata_beat_bytes),
		.count_q(ata_count),
		.count_zero(ata_count_zero)
	);

	// every byte write reseeds, so the last write of a load sequence wins
	tbcr_sector_counter #(
		.CW(`TBCR_SECT_W),
		.BEAT_W(BEAT_W),
		.SECTOR_BYTES(SECTOR_BYTES)
	) u_sector (
		.clk(clk),
		.rst_b(rst_b),
		.seed_en(seed_en),
		.seed_val(merged[`TBCR_SEED_MSB:`TBCR_SEED_LSB]),
		.pio_mode(ata_pio_mode),
		.beat_valid(ata_beat_valid),
		.beat_bytes(ata_beat_bytes),
		.count_q(sector_counter),
		.count_zero(sector_count_zero)
	);

	assign sel_count = (count_set_read_select == `TBCR_SEL_ATA) ? ata_count : usb_count;

	// read data is registered: valid one cycle after the strobe
	always @* begin
		rdata_d = `TBCR_UNMAPPED_DATA;
		hit_d = 1'b1;
		if (rd_reg == REG_SECT_LOW) begin
			rdata_d = sector_counter[7:0];
		end else if (rd_reg == REG_SECT_MSB) begin
			rdata_d = 8'h00;
			rdata_d[`TBCR_SECT_MSB_BIT] = sector_counter[8];
		end else if (rd_reg != REG_NONE) begin
			rdata_d = tbcr_lane(sel_count, rd_lane);
		end else begin
			hit_d = 1'b0;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mcu_rdata_q <= 8'h00;
			mcu_rdata_valid_q <= 1'b0;
			mcu_rdata_hit_q <= 1'b0;
		end else begin
			mcu_rdata_valid_q <= mcu_rd;
			if (mcu_rd) begin
				mcu_rdata_q <= rdata_d;
				mcu_rdata_hit_q <= hit_d;
			end
		end
	end

	// a command ending with a byte count left over, or a sector count left in pio mode,
	// is flagged; cleared by the next load, but a simultaneous end still sets it
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			abnormal_end_q <= 1'b0;
		end else if (cmd_end) begin
			abnormal_end_q <= ~(usb_count_zero & ata_count_zero
				& (sector_count_zero | ~ata_pio_mode));
		end else if (seed_en) begin
			abnormal_end_q <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// *** logic/tbcr_defines.vh ***
`ifndef TBCR_DEFINES_VH
`define TBCR_DEFINES_VH

// register addresses on the mcu data bus
`define TBCR_ADDR_SECT_MSB 16'hf0d4
`define TBCR_ADDR_SECT_LOW 16'hf0d5
`define TBCR_ADDR_XFER_B0 16'hf0d6
`define TBCR_ADDR_XFER_B1 16'hf0d7
`define TBCR_ADDR_XFER_B2 16'hf0d8
`define TBCR_ADDR_XFER_B3 16'hf0d9

// reset values
`define TBCR_RST_XFER_BYTE 8'h00
`define TBCR_RST_SECT_LOW 8'h00
`define TBCR_RST_SECT_MSB 1'b0
`define TBCR_UNMAPPED_DATA 8'h00

// field positions
`define TBCR_SEED_LSB 9
`define TBCR_SEED_MSB 17
`define TBCR_SECT_MSB_BIT 0

// read-back select encoding
`define TBCR_SEL_USB 1'b0
`define TBCR_SEL_ATA 1'b1

// counting constants
`define TBCR_SECTOR_BYTES 512
`define TBCR_XFER_BYTES 4
`define TBCR_SECT_W 9
`define TBCR_BEAT_W 3

`endif

// *** logic/tbcr_byte_counter.v ***
`default_nettype none

module tbcr_byte_counter #(
	parameter NBYTES = 4,
	parameter BEAT_W = 3
) (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// mcu load, one enable per byte lane
	input wire [NBYTES-1:0] load_byte_en,
	input wire [7:0] load_data,
	// traffic on this side
	input wire beat_valid,
	input wire [BEAT_W-1:0] beat_bytes,
	// state
	output reg [8*NBYTES-1:0] count_q,
	output wire count_zero
);

	localparam W = 8 * NBYTES;

	reg [W-1:0] count_d;
	reg [W-1:0] beat_ext;
	integer i;

	// a load beats a beat in the same cycle: firmware reseeds between commands
	always @* begin
		count_d = count_q;
		beat_ext = {{(W-BEAT_W){1'b0}}, beat_bytes};
		if (|load_byte_en) begin
			for (i = 0; i < NBYTES; i = i + 1) begin
				if (load_byte_en[i]) begin
					count_d[8*i +: 8] = load_data;
				end
			end
		end else if (beat_valid) begin
			if (count_q > beat_ext) begin
				count_d = count_q - beat_ext;
			end else begin
				count_d = {W{1'b0}};
			end
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= {W{1'b0}};
		end else begin
			count_q <= count_d;
		end
	end

	assign count_zero = (count_q == {W{1'b0}});

endmodule

`default_nettype wire

// *** logic/tbcr_sector_counter.v ***
`default_nettype none

module tbcr_sector_counter #(
	parameter CW = 9,
	parameter BEAT_W = 3,
	parameter SECTOR_BYTES = 512
) (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// seed from the byte-count load
	input wire seed_en,
	input wire [CW-1:0] seed_val,
	// disk-side traffic
	input wire pio_mode,
	input wire beat_valid,
	input wire [BEAT_W-1:0] beat_bytes,
	// state
	output reg [CW-1:0] count_q,
	output wire count_zero
);

	localparam AW = 11;
	localparam [AW-1:0] SECT = SECTOR_BYTES[AW-1:0];

	reg [AW-1:0] acc_q;
	reg [AW-1:0] acc_d;
	reg [AW-1:0] sum;
	reg [CW-1:0] count_d;

	always @* begin
		acc_d = acc_q;
		count_d = count_q;
		sum = acc_q + {{(AW-BEAT_W){1'b0}}, beat_bytes};
		if (seed_en) begin
			count_d = seed_val;
			acc_d = {AW{1'b0}};
		end else if (beat_valid && pio_mode) begin
			if (sum >= SECT) begin
				acc_d = sum - SECT;
				// floor at zero: an overrun must not wrap to a huge count
				if (count_q != {CW{1'b0}}) begin
					count_d = count_q - {{(CW-1){1'b0}}, 1'b1};
				end
			end else begin
				acc_d = sum;
			end
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= {CW{1'b0}};
			acc_q <= {AW{1'b0}};
		end else begin
			count_q <= count_d;
			acc_q <= acc_d;
		end
	end

	assign count_zero = (count_q == {CW{1'b0}});

endmodule

`default_nettype wire

// *** testbench/tbcr_regs_chk.sv ***
`include "tbcr_defines.vh"
`default_nettype none

module tbcr_regs_chk #(
	parameter BEAT_W = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// mcu bus
	input wire logic [15:0] mcu_addr,
	input wire logic mcu_wr,
	input wire logic mcu_rd,
	input wire logic [7:0] mcu_wdata,
	input wire logic [7:0] mcu_rdata_q,
	input wire logic mcu_rdata_valid_q,
	input wire logic mcu_rdata_hit_q,
	// config and traffic
	input wire logic count_set_read_select,
	input wire logic ata_pio_mode,
	input wire logic usb_beat_valid,
	input wire logic [BEAT_W-1:0] usb_beat_bytes,
	input wire logic ata_beat_valid,
	input wire logic [BEAT_W-1:0] ata_beat_bytes,
	// status
	input wire logic cmd_end,
	input wire logic usb_count_zero,
	input wire logic ata_count_zero,
	input wire logic sector_count_zero,
	input wire logic [8:0] sector_counter,
	input wire logic abnormal_end_q
);
	logic [7:0] wd_q;

	// last write data, so the seed can be tied to it
	always @(posedge clk) begin
		wd_q <= mcu_wdata;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	a_read_valid_pulse: assert property (mcu_rd |=> mcu_rdata_valid_q)
		else $error("read valid missing");
	a_valid_has_cause: assert property (mcu_rdata_valid_q |-> $past(mcu_rd))
		else $error("read valid without read");
	a_rdata_holds: assert property (!mcu_rd |=> $stable(mcu_rdata_q))
		else $error("read data moved without read");
	a_unmapped_zero: assert property (mcu_rd && mcu_addr == 16'h0000 |=>
		mcu_rdata_q == 8'h00 && !mcu_rdata_hit_q) else $error("unmapped read wrong");
	a_load_both_sets: assert property (mcu_wr && mcu_addr == `TBCR_ADDR_XFER_B0 &&
		mcu_wdata != 8'h00 |=> !usb_count_zero && !ata_count_zero)
		else $error("write did not load both sets");
	a_seed_mid_bits: assert property (mcu_wr && mcu_addr == `TBCR_ADDR_XFER_B1 |=>
		sector_counter[6:0] == wd_q[7:1]) else $error("sector seed wrong");
	a_sector_no_pio: assert property (!ata_pio_mode && !mcu_wr |=>
		$stable(sector_counter)) else $error("sector moved outside pio");
	a_abnormal_flag: assert property (cmd_end && !usb_count_zero |=> abnormal_end_q)
		else $error("abnormal end not flagged");
	a_sector_step: assert property (ata_pio_mode && !mcu_wr |=>
		sector_counter == $past(sector_counter) ||
		sector_counter == $past(sector_counter) - 9'h001)
		else $error("sector count jumped");
	a_sector_zero_flag: assert property (sector_count_zero == (sector_counter == 9'h000))
		else $error("sector zero flag wrong");
	a_idle_usb_hold: assert property (!usb_beat_valid && !mcu_wr |=>
		$stable(usb_count_zero)) else $error("usb count moved without traffic");
	a_idle_ata_hold: assert property (!ata_beat_valid && !mcu_wr |=>
		$stable(ata_count_zero)) else $error("ata count moved without traffic");
endmodule

bind tbcr_regs tbcr_regs_chk #(.BEAT_W(BEAT_W)) u_chk (.*);

`default_nettype wire

// *** testbench/tb_tbcr_regs.sv ***
`include "tbcr_defines.vh"
`default_nettype none

module tb_tbcr_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_b, mcu_wr, mcu_rd, count_set_read_select, ata_pio_mode, cmd_end;
	logic usb_beat_valid, ata_beat_valid, mcu_rdata_valid_q, mcu_rdata_hit_q;
	logic usb_count_zero, ata_count_zero, sector_count_zero, abnormal_end_q;
	logic [15:0] mcu_addr;
	logic [7:0] mcu_wdata, mcu_rdata_q;
	logic [2:0] usb_beat_bytes, ata_beat_bytes;
	logic [8:0] sector_counter;
	int fail_count, n_tests;

	tbcr_regs uut (.*);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask

	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		mcu_addr <= a;
		mcu_wdata <= d;
		mcu_wr <= 1'b1;
		@(posedge clk);
		mcu_wr <= 1'b0;
	endtask

	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		mcu_addr <= a;
		mcu_rd <= 1'b1;
		@(posedge clk);
		mcu_rd <= 1'b0;
		#1 chk("rvalid", 1'b1, mcu_rdata_valid_q);
		chk("rdata", e, mcu_rdata_q);
		chk("rhit", a >= `TBCR_ADDR_SECT_MSB && a <= `TBCR_ADDR_XFER_B3, mcu_rdata_hit_q);
	endtask

	task ld(input logic [31:0] v);
		for (int i = 0; i < 4; i++) wr(`TBCR_ADDR_XFER_B0 + 16'(i), v[8*i+:8]);
	endtask

	task rd32(input logic s, input logic [31:0] e);
		@(posedge clk);
		count_set_read_select <= s;
		for (int i = 0; i < 4; i++) rd(`TBCR_ADDR_XFER_B0 + 16'(i), e[8*i+:8]);
	endtask

	// one burst of back-to-back beats on one side
	task beat(input logic u, input int n, input logic [2:0] b);
		@(posedge clk);
		usb_beat_valid <= u;
		ata_beat_valid <= !u;
		usb_beat_bytes <= b;
		ata_beat_bytes <= b;
		repeat (n) @(posedge clk);
		usb_beat_valid <= 1'b0;
		ata_beat_valid <= 1'b0;
	endtask

	task end_cmd;
		@(posedge clk);
		cmd_end <= 1'b1;
		@(posedge clk);
		cmd_end <= 1'b0;
		#1;
	endtask

	task t_reset;
		rd(`TBCR_ADDR_SECT_MSB, 8'h00);
		rd(`TBCR_ADDR_SECT_LOW, 8'h00);
		rd32(1'b0, 32'h0);
		rd32(1'b1, 32'h0);
		rd(16'h0000, 8'h00);
		chk("hit", 1'b0, mcu_rdata_hit_q);
	endtask

	// 1028 bytes: two sectors plus a tail of four bytes
	task t_pio_count;
		@(posedge clk);
		ata_pio_mode <= 1'b1;
		ld(32'h0000_0404);
		rd32(1'b0, 32'h404);
		rd32(1'b1, 32'h404);
		rd(`TBCR_ADDR_SECT_LOW, 8'h02);
		beat(1'b0, 128, 3'h4);
		#1 chk("sector", 9'h001, sector_counter);
		rd32(1'b1, 32'h204);
		rd32(1'b0, 32'h404);
		beat(1'b0, 129, 3'h4);
		beat(1'b1, 257, 3'h4);
		beat(1'b0, 1, 3'h7);
		#1 chk("ata zero", 1'b1, ata_count_zero);
		chk("usb zero", 1'b1, usb_count_zero);
		chk("sector zero", 1'b1, sector_count_zero);
		end_cmd();
		chk("abnormal", 1'b0, abnormal_end_q);
	endtask

	task t_abnormal;
		@(posedge clk);
		ata_pio_mode <= 1'b0;
		ld(32'h0000_0404);
		beat(1'b0, 2, 3'h4);
		rd32(1'b1, 32'h3fc);
		chk("sector", 9'h002, sector_counter);
		end_cmd();
		chk("abnormal", 1'b1, abnormal_end_q);
		wr(`TBCR_ADDR_SECT_LOW, 8'hff);
		rd(`TBCR_ADDR_SECT_LOW, 8'h02);
		ld(32'h0002_0404);
		#1 chk("abn clear", 1'b0, abnormal_end_q);
		rd(`TBCR_ADDR_SECT_MSB, 8'h01);
		rd(`TBCR_ADDR_SECT_LOW, 8'h02);
	endtask

	// reset after an abnormal command end must drop every count and the flag
	task t_mid_reset;
		end_cmd();
		chk("abnormal", 1'b1, abnormal_end_q);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("rst flags", 4'he,
			{usb_count_zero, ata_count_zero, sector_count_zero, abnormal_end_q});
		@(posedge clk);
		rst_b <= 1'b1;
		rd32(1'b0, 32'h0);
		rd32(1'b1, 32'h0);
		rd(`TBCR_ADDR_SECT_LOW, 8'h00);
		rd(`TBCR_ADDR_SECT_MSB, 8'h00);
	endtask

	task final_report;
		$display("mismatches %0d, checks %0d", fail_count, n_tests);
		if (fail_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// whole run is about 700 cycles, the limit about 4000
	initial begin
		#100us;
		fail_count++;
		final_report();
	end

	initial begin
		{rst_b, mcu_wr, mcu_rd, count_set_read_select, ata_pio_mode, cmd_end} = 6'h00;
		{usb_beat_valid, ata_beat_valid, usb_beat_bytes, ata_beat_bytes} = 8'h00;
		mcu_addr = 16'h0000;
		mcu_wdata = 8'h00;
		fail_count = 0;
		n_tests = 0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_pio_count();
		t_abnormal();
		t_mid_reset();
		final_report();
	end
endmodule

`default_nettype wire
